// [design/ets_pkg.sv]
// package for the extinction trigger scheduler: APB map, fields, timing
// assumes a 125 MHz core clock; tick rate derived from a divider
package ets_pkg;
	// tick clock period and ring structure
	localparam int TICK_PS         = 24900;
	localparam int CLK_PS          = 8000;
	localparam int TICK_PER_BUNCH  = 68;
	localparam int INTIME_TICKS    = 10;
	localparam int OUTTIME_TICKS   = TICK_PER_BUNCH - INTIME_TICKS;
	localparam int PRESCALE_RST    = 10;
	localparam int MIN_SPACING     = 5;
	localparam int READOUT_TICKS   = 6;
	localparam int DEAD_TICKS      = 1;
	localparam int NUM_PLANES      = 4;
	localparam int PULSE_NS        = 250;
	localparam int PULSE_TICKS     = (PULSE_NS * 1000 + TICK_PS - 1) / TICK_PS;
	// core cycles per tick, rounded down so ticks never drift long
	localparam int CYC_PER_TICK    = TICK_PS / CLK_PS;
	// register byte offsets
	localparam logic [7:0] OFF_CTRL     = 8'h00;
	localparam logic [7:0] OFF_PRESCALE = 8'h04;
	localparam logic [7:0] OFF_MARGIN   = 8'h08;
	localparam logic [7:0] OFF_STATUS   = 8'h0C;
	localparam logic [7:0] OFF_TRIGCNT  = 8'h10;
	localparam logic [7:0] OFF_STAMP    = 8'h14;
	// field positions
	localparam int CTRL_EN_BIT     = 0;
	localparam int STAT_INTIME_BIT = 0;
	localparam int STAT_PULSE_BIT  = 1;
	localparam logic [7:0] MARGIN_RST = 8'h11;
	// trigger command state per plane
	typedef enum logic [1:0]
	{
		ETS_IDLE = 2'b00,
		ETS_READ = 2'b01,
		ETS_DEAD = 2'b10
	} ets_plane_e;
	typedef struct packed
	{
		logic [2:0] up;
		logic [2:0] down;
	} ets_disc_s;
endpackage

// [design/ets_sync.sv]
// two-stage synchroniser for a bus of discriminator levels
// assumes inputs are asynchronous to core_clk
`timescale 1ns/1ps
`default_nettype none
module ets_sync #(
	parameter int W = 6
) (
	input  wire logic         core_clk,
	input  wire logic         rst,
	input  wire logic [W-1:0] din,
	output logic      [W-1:0] dout
);
	typedef struct packed
	{
		logic [W-1:0] s1;
		logic [W-1:0] s2;
	} ets_sync_s;
	ets_sync_s st_q;
	ets_sync_s st_d;
	// first stage is read only by the second
	always_comb
	begin
		st_d = st_q;
		st_d.s1 = din;
		st_d.s2 = st_q.s1;
	end
	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst)
			st_q <= '0;
		else
			st_q <= st_d;
	end
	assign dout = st_q.s2;
endmodule
`default_nettype wire

// [design/ets_plane.sv]
// one pixel plane trigger command sequencer: read window then dead tick
// assumes tickStb is a single-cycle pulse per tick
`timescale 1ns/1ps
`default_nettype none
module ets_plane (
	input  wire logic core_clk,
	input  wire logic rst,
	input  wire logic tickStb,
	input  wire logic fire,
	output logic      cmdOut,
	output logic      busy,
	output logic      dead
);
	typedef struct packed
	{
		ets_pkg::ets_plane_e st;
		logic [3:0]          cnt;
		logic                cmd;
	} ets_plane_s;
	ets_plane_s st_q;
	ets_plane_s st_d;
	// fire accepted only when idle, so spacing is eight ticks: six read, one dead, one idle
	always_comb
	begin
		st_d = st_q;
		st_d.cmd = 1'b0;
		if (tickStb)
		begin
			case (st_q.st)
				ets_pkg::ETS_IDLE:
				begin
					if (fire)
					begin
						st_d.st = ets_pkg::ETS_READ;
						st_d.cmd = 1'b1;
						st_d.cnt = 4'(ets_pkg::READOUT_TICKS - 1);
					end
				end
				ets_pkg::ETS_READ:
				begin
					if (st_q.cnt == 4'h0)
					begin
						st_d.st = ets_pkg::ETS_DEAD;
						st_d.cnt = 4'(ets_pkg::DEAD_TICKS - 1);
					end
					else
						st_d.cnt = st_q.cnt - 4'h1;
				end
				ets_pkg::ETS_DEAD:
				begin
					if (st_q.cnt == 4'h0)
						st_d.st = ets_pkg::ETS_IDLE;
					else
						st_d.cnt = st_q.cnt - 4'h1;
				end
				default: st_d.st = ets_pkg::ETS_IDLE;
			endcase
		end
	end
	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst)
			st_q <= '0;
		else
			st_q <= st_d;
	end
	assign cmdOut = st_q.cmd;
	assign busy   = st_q.st != ets_pkg::ETS_IDLE;
	assign dead   = st_q.st == ets_pkg::ETS_DEAD;
	// spacing never below five ticks: fourteen quiet cycles after each
	a_cmd_spacing: assert property
		(@(posedge core_clk) disable iff (rst)
		cmdOut |=> !cmdOut [*8] ##1 !cmdOut [*6])
		else $error("plane command repeated too soon");
	a_dead_no_cmd: assert property
		(@(posedge core_clk) disable iff (rst)
		dead |=> !cmdOut)
		else $error("command issued during dead tick");
endmodule
`default_nettype wire

// [design/ets_top.sv]
// trigger scheduler for a two-stack pixel telescope with APB registers
// assumes discriminator inputs are asynchronous; core_clk is 125 MHz
`timescale 1ns/1ps
`default_nettype none
module ets_top #(
	parameter int NPLANE = ets_pkg::NUM_PLANES
) (
	input  wire logic              core_clk,
	input  wire logic              rst,
	input  wire logic              psel,
	input  wire logic              penable,
	input  wire logic              pwrite,
	input  wire logic [7:0]        paddr,
	input  wire logic [31:0]       pwdata,
	output logic      [31:0]       prdata,
	output logic                   pready,
	output logic                   pslverr,
	input  wire ets_pkg::ets_disc_s disc,
	input  wire logic [15:0]       stampIn,
	output logic      [NPLANE-1:0] upCmd,
	output logic      [NPLANE-1:0] downCmd,
	output logic                   inTime,
	output logic                   pulseStart,
	output logic                   pulseEnd,
	output logic      [7:0]        winFirst,
	output logic      [7:0]        winLast
);
	typedef struct packed
	{
		logic                         en;
		logic [7:0]                   prescale;
		logic [7:0]                   margin;
		logic [4:0]                   div;
		logic [6:0]                   tick;
		logic [7:0]                   psCnt;
		logic                         bunchTaken;
		logic [31:0]                  trigCnt;
		logic [15:0]                  stamp;
		logic                         pend;
		logic [NPLANE-1:0]            hot;
		logic                         inPulse;
		logic                         pStart;
		logic                         pEnd;
		logic [7:0]                   wFirst;
		logic [7:0]                   wLast;
		logic [31:0]                  rdata;
	} ets_top_s;
	ets_top_s st_q;
	ets_top_s st_d;

	ets_pkg::ets_disc_s discS;
	logic [5:0]         discRaw;
	logic [5:0]         discSync;
	logic               tickStb;
	logic               upOk;
	logic               downOk;
	logic               coinc;
	logic               accept;
	logic [NPLANE-1:0]  upBusy;
	logic [NPLANE-1:0]  upDead;
	logic [NPLANE-1:0]  downBusy;
	logic [NPLANE-1:0]  downDead;
	logic [NPLANE-1:0]  upFire;
	logic [NPLANE-1:0]  downFire;
	logic               wrEn;
	logic               rdEn;
	logic [15:0]        stampSync;

	assign discRaw = disc;
	ets_sync #(
		.W(6)
	) u_sync (
		.core_clk(core_clk),
		.rst     (rst),
		.din     (discRaw),
		.dout    (discSync)
	);
	assign discS = discSync;

	// stamp word sits steady around each hit, so a two-flop copy lands
	// whole and keeps pace with the discriminator path latency
	ets_sync #(
		.W(16)
	) u_stamp_sync (
		.core_clk(core_clk),
		.rst     (rst),
		.din     (stampIn),
		.dout    (stampSync)
	);

	// two-of-three majority per side, then both sides together
	assign upOk   = (discS.up[0] & discS.up[1]) | (discS.up[0] & discS.up[2])
		| (discS.up[1] & discS.up[2]);
	assign downOk = (discS.down[0] & discS.down[1])
		| (discS.down[0] & discS.down[2])
		| (discS.down[1] & discS.down[2]);
	assign coinc  = upOk & downOk;

	// tick strobe: divider approximates the accelerator-locked tick
	assign tickStb = st_q.div == 5'(ets_pkg::CYC_PER_TICK - 1);
	assign inTime  = st_q.tick < 7'(ets_pkg::INTIME_TICKS);

	// out-of-time always passes; in-time passes one bunch in N
	always_comb
	begin
		accept = 1'b0;
		if (st_q.en && tickStb && coinc)
		begin
			if (!inTime)
				accept = 1'b1;
			else if (!st_q.bunchTaken
				&& st_q.psCnt >= st_q.prescale - 8'h1)
				accept = 1'b1;
		end
	end

	// one plane per stack fired at a time, waiting while the hot one is busy
	genvar gi;
	generate
		for (gi = 0; gi < NPLANE; gi++)
		begin : g_plane
			assign upFire[gi]   = st_q.hot[gi] & ~upBusy[gi]
				& (st_q.pend | accept);
			assign downFire[gi] = st_q.hot[gi] & ~downBusy[gi]
				& (st_q.pend | accept);
			ets_plane u_up (
				.core_clk(core_clk),
				.rst     (rst),
				.tickStb (tickStb),
				.fire    (upFire[gi]),
				.cmdOut  (upCmd[gi]),
				.busy    (upBusy[gi]),
				.dead    (upDead[gi])
			);
			ets_plane u_down (
				.core_clk(core_clk),
				.rst     (rst),
				.tickStb (tickStb),
				.fire    (downFire[gi]),
				.cmdOut  (downCmd[gi]),
				.busy    (downBusy[gi]),
				.dead    (downDead[gi])
			);
		end
	endgenerate

	// APB: zero wait states, unmapped addresses read zero with no error
	assign wrEn    = psel & penable & pwrite;
	assign rdEn    = psel & ~penable & ~pwrite;
	assign pready  = 1'b1;
	assign pslverr = 1'b0;

	// main next-state process
	always_comb
	begin
		st_d = st_q;
		st_d.pStart = 1'b0;
		st_d.pEnd = 1'b0;
		st_d.div = tickStb ? 5'h0 : st_q.div + 5'h1;
		if (tickStb)
		begin
			// free-running tick counter within one bunch period
			if (st_q.tick == 7'(ets_pkg::TICK_PER_BUNCH - 1))
			begin
				st_d.tick = 7'h0;
				st_d.bunchTaken = 1'b0;
			end
			else
				st_d.tick = st_q.tick + 7'h1;
			// prescaler counts in-time bunches with a candidate
			if (st_q.en && inTime && coinc && !st_q.bunchTaken)
			begin
				st_d.bunchTaken = 1'b1;
				if (st_q.psCnt >= st_q.prescale - 8'h1)
					st_d.psCnt = 8'h0;
				else
					st_d.psCnt = st_q.psCnt + 8'h1;
			end
			// beam pulse edges from the coincidence level sampled each tick
			if (coinc && !st_q.inPulse)
			begin
				st_d.inPulse = 1'b1;
				st_d.pStart = 1'b1;
			end
			else if (!coinc && st_q.inPulse)
			begin
				st_d.inPulse = 1'b0;
				st_d.pEnd = 1'b1;
			end
			// hold a pending trigger until the free hot planes of both stacks take it in one tick
			if (accept || st_q.pend)
				st_d.pend = !((|upFire) && (|downFire));
			if ((|upFire) || (|downFire))
			begin
				// hand the turn on; planes of one stack never share a dead tick
				st_d.hot = {st_q.hot[NPLANE-2:0], st_q.hot[NPLANE-1]};
			end
		end
		if (accept)
		begin
			st_d.trigCnt = st_q.trigCnt + 32'h1;
			// readout window widened by margins each side
			st_d.wFirst = 8'(st_q.tick) - st_q.margin[3:0];
			st_d.wLast = 8'(st_q.tick) + st_q.margin[7:4];
			if (!inTime)
				st_d.stamp = stampSync;
		end
		if (wrEn)
		begin
			case (paddr)
				ets_pkg::OFF_CTRL:     st_d.en = pwdata[ets_pkg::CTRL_EN_BIT];
				ets_pkg::OFF_PRESCALE:
				begin
					st_d.prescale = (pwdata[7:0] == 8'h0) ? 8'h1
						: pwdata[7:0];
					// restart the count so it never sits past a lowered factor
					st_d.psCnt = 8'h0;
				end
				ets_pkg::OFF_MARGIN:   st_d.margin = pwdata[7:0];
				default:               st_d.en = st_q.en;
			endcase
		end
		if (rdEn)
		begin
			case (paddr)
				ets_pkg::OFF_CTRL:     st_d.rdata = {31'h0, st_q.en};
				ets_pkg::OFF_PRESCALE: st_d.rdata = {24'h0, st_q.prescale};
				ets_pkg::OFF_MARGIN:   st_d.rdata = {24'h0, st_q.margin};
				ets_pkg::OFF_STATUS:
					st_d.rdata = {23'h0, st_q.tick, st_q.inPulse, inTime};
				ets_pkg::OFF_TRIGCNT:  st_d.rdata = st_q.trigCnt;
				ets_pkg::OFF_STAMP:    st_d.rdata = {16'h0, st_q.stamp};
				default:               st_d.rdata = 32'h0;
			endcase
		end
	end

	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst)
		begin
			st_q <= '0;
			st_q.prescale <= 8'(ets_pkg::PRESCALE_RST);
			st_q.margin <= ets_pkg::MARGIN_RST;
			st_q.hot <= NPLANE'(1);
		end
		else
			st_q <= st_d;
	end

	assign prdata     = st_q.rdata;
	assign pulseStart = st_q.pStart;
	assign pulseEnd   = st_q.pEnd;
	assign winFirst   = st_q.wFirst;
	assign winLast    = st_q.wLast;

	// checks
	a_tick_wrap: assert property
		(@(posedge core_clk) disable iff (rst)
		st_q.tick < 7'(ets_pkg::TICK_PER_BUNCH))
		else $error("tick counter out of range");
	a_intime_map: assert property
		(@(posedge core_clk) disable iff (rst)
		inTime == (st_q.tick < 7'(ets_pkg::INTIME_TICKS)))
		else $error("in-time region wrong");
	a_coinc_sides: assert property
		(@(posedge core_clk) disable iff (rst)
		coinc |-> ($countones(discS.up) >= 2 && $countones(discS.down) >= 2))
		else $error("coincidence without both sides");
	a_out_no_pre: assert property
		(@(posedge core_clk) disable iff (rst)
		(st_q.en && tickStb && coinc && !inTime) |-> accept)
		else $error("out-of-time trigger dropped");
	a_one_dead_up: assert property
		(@(posedge core_clk) disable iff (rst)
		$countones(upDead) <= 1)
		else $error("two upstream planes dead");
	a_one_dead_dn: assert property
		(@(posedge core_clk) disable iff (rst)
		$countones(downDead) <= 1)
		else $error("two downstream planes dead");
	a_window_after: assert property
		(@(posedge core_clk) disable iff (rst)
		accept |=> winFirst
			== 8'($past(st_q.tick)) - $past(st_q.margin[3:0]))
		else $error("window margin wrong");
	a_prescale_wrap: assert property
		(@(posedge core_clk) disable iff (rst)
		st_q.psCnt < st_q.prescale)
		else $error("prescale count passed factor");
	a_pulse_pair: assert property
		(@(posedge core_clk) disable iff (rst)
		pulseStart |-> !pulseEnd)
		else $error("pulse start and end together");
	c_out_trig: cover property (@(posedge core_clk) accept && !inTime);
	c_in_trig: cover property (@(posedge core_clk) accept && inTime);
	c_pulse: cover property (@(posedge core_clk) pulseStart);
	c_wrap: cover property (@(posedge core_clk)
		tickStb && st_q.tick == 7'(ets_pkg::TICK_PER_BUNCH - 1));
endmodule
`default_nettype wire

// [verif/ets_chip_model.sv]
// stand-in for one pixel readout chip on a plane's trigger command line
// assumes core_clk cycles map to ticks by ets_pkg::CYC_PER_TICK
`timescale 1ns/1ps
`default_nettype none
module ets_chip_model (
	input  wire logic       core_clk,
	input  wire logic       rst,
	input  wire logic       cmd,
	output logic            dead,
	output logic      [7:0] errs
);
	localparam int CT  = ets_pkg::CYC_PER_TICK;
	localparam int RD  = ets_pkg::READOUT_TICKS * CT;
	localparam int GAP = RD + ets_pkg::DEAD_TICKS * CT;
	localparam int COLS = 80;
	localparam int ROWS = 336;
	int age;
	// hit report of the last readout: pixel, hit tick, charge duration
	logic [6:0] hitCol;
	logic [8:0] hitRow;
	logic [3:0] hitTime;
	logic [3:0] chargeDurationTicks;
	// fixed readout then one dead tick; an early command is counted
	// as a fault, the chip never forgives it
	always @(posedge core_clk or posedge rst)
	begin
		if (rst)
		begin
			age  <= GAP + 1;
			errs <= 8'h00;
			hitCol <= 7'h00;
			hitRow <= 9'h000;
			hitTime <= 4'h0;
			chargeDurationTicks <= 4'h0;
		end
		else if (cmd)
		begin
			if (age < GAP)
				errs <= errs + 8'h01;
			age <= 1;
			// next pixel in raster order, kept inside the matrix
			if (hitCol == 7'(COLS - 1))
			begin
				hitCol <= 7'h00;
				hitRow <= (hitRow == 9'(ROWS - 1)) ? 9'h000
					: hitRow + 9'h001;
			end
			else
				hitCol <= hitCol + 7'h01;
			hitTime <= 4'(ets_pkg::READOUT_TICKS - 1);
			chargeDurationTicks <= 4'h2;
		end
		else if (age <= GAP)
			age <= age + 1;
	end
	// dead window, coarse to the core cycle
	assign dead = (age > RD) && (age <= GAP);
endmodule
`default_nettype wire

// [verif/testbench.sv]
// self-checking bench for the trigger scheduler: APB, coincidences, planes
// assumes ets_top and ets_chip_model are compiled before it
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin \
	miscompares++; $display("FAIL %0t got %0h exp %0h", $time, g, e); \
	end end
module testbench;
	localparam int NP = ets_pkg::NUM_PLANES;
	localparam int CT = ets_pkg::CYC_PER_TICK;
	localparam logic [5:0] COIN = 6'h1D;
	typedef struct packed {logic w; logic [7:0] a; logic [31:0] d;} ets_row_s;
	typedef struct packed {logic [5:0] p; logic t;} ets_coin_s;
	logic                core_clk = 1'b0;
	logic                rst, psel, penable, pwrite, pready, pslverr;
	logic                inTime, pulseStart, pulseEnd;
	logic [7:0]          paddr, winFirst, winLast;
	logic [31:0]         pwdata, prdata, rdv;
	logic [15:0]         stampIn;
	logic [NP-1:0]       upCmd, downCmd, upDead, dnDead;
	logic [7:0]          upErr [NP];
	logic [7:0]          dnErr [NP];
	ets_pkg::ets_disc_s  disc;
	int                  miscompares = 0, comparisons = 0, n;
	int                  nUp, nDn, nStart, nEnd, clash;
	// reads carry the expected word in d; writes carry the data
	ets_row_s regRows [10] = '{'{1'b0, ets_pkg::OFF_PRESCALE, 32'h0000000A},
		'{1'b0, ets_pkg::OFF_MARGIN, 32'h00000011},
		'{1'b0, ets_pkg::OFF_CTRL, 32'h00000000},
		'{1'b0, ets_pkg::OFF_TRIGCNT, 32'h00000000},
		'{1'b1, ets_pkg::OFF_MARGIN, 32'h00000032},
		'{1'b0, ets_pkg::OFF_MARGIN, 32'h00000032},
		'{1'b1, 8'h18, 32'hFFFFFFFF},
		'{1'b0, 8'h18, 32'h00000000},
		'{1'b1, ets_pkg::OFF_CTRL, 32'h00000001},
		'{1'b0, ets_pkg::OFF_CTRL, 32'h00000001}};
	// up bits above down bits, expected trigger beside each pattern
	ets_coin_s coinRows [6] = '{'{6'h1D, 1'b1}, '{6'h0F, 1'b0},
		'{6'h3C, 1'b0}, '{6'h36, 1'b1}, '{6'h2B, 1'b1}, '{6'h00, 1'b0}};

	always #4 core_clk = ~core_clk;

	ets_top #(.NPLANE(NP)) u_ets_top (.core_clk(core_clk), .rst(rst),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .disc(disc), .stampIn(stampIn), .upCmd(upCmd),
		.downCmd(downCmd), .inTime(inTime), .pulseStart(pulseStart),
		.pulseEnd(pulseEnd), .winFirst(winFirst), .winLast(winLast));

	// one chip model per plane on each side
	for (genvar k = 0; k < NP; k++)
	begin : g_up
		ets_chip_model u_ets_chip_model (.core_clk(core_clk), .rst(rst),
			.cmd(upCmd[k]), .dead(upDead[k]), .errs(upErr[k]));
	end
	for (genvar k = 0; k < NP; k++)
	begin : g_dn
		ets_chip_model u_ets_chip_model (.core_clk(core_clk), .rst(rst),
			.cmd(downCmd[k]), .dead(dnDead[k]), .errs(dnErr[k]));
	end

	// event counters; two dead planes in one stack is a clash
	always @(posedge core_clk)
	begin
		nUp += $countones(upCmd);
		nDn += $countones(downCmd);
		nStart += int'(pulseStart === 1'b1);
		nEnd += int'(pulseEnd === 1'b1);
		clash += int'($countones(upDead) > 1 || $countones(dnDead) > 1);
	end

	task automatic results();
		$display("comparisons %0d miscompares %0d", comparisons, miscompares);
		if (miscompares == 0 && comparisons > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	// setup edge, access edge, hold until pready seen high
	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		@(posedge core_clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge core_clk);
		penable <= 1'b1;
		do
			@(posedge core_clk);
		while (pready !== 1'b1);
		rdv = prdata;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic waitIn(input logic v);
		while (inTime !== v)
			@(posedge core_clk);
	endtask

	// pattern held for some cycles, early in the chosen region
	task automatic fire(input logic [5:0] p, input int hold, input logic ph);
		waitIn(!ph);
		waitIn(ph);
		repeat (9) @(posedge core_clk);
		disc <= ets_pkg::ets_disc_s'(p);
		repeat (hold) @(posedge core_clk);
		disc <= '0;
		repeat (60) @(posedge core_clk);
	endtask

	// the tests need well under ten thousand cycles; a hang ends here
	initial
	begin
		repeat (40000) @(posedge core_clk);
		miscompares++;
		results();
	end

	initial
	begin
		{rst, psel, penable, pwrite} = 4'h8;
		paddr = 8'h00;
		pwdata = 32'h00000000;
		disc = '0;
		stampIn = 16'h0000;
		repeat (16) @(posedge core_clk);
		rst <= 1'b0;
		foreach (regRows[i])
		begin
			apb(regRows[i].w, regRows[i].a, regRows[i].d);
			`CHK({pready, pslverr}, 2'b10)
			if (!regRows[i].w)
				`CHK(rdv, regRows[i].d)
		end
		// in-time span and out-of-time span
		waitIn(1'b0);
		waitIn(1'b1);
		n = 0;
		while (inTime === 1'b1)
		begin
			@(posedge core_clk);
			n++;
		end
		`CHK(n, ets_pkg::INTIME_TICKS * CT)
		n = 0;
		while (inTime === 1'b0)
		begin
			@(posedge core_clk);
			n++;
		end
		`CHK(n, ets_pkg::OUTTIME_TICKS * CT)
		// one-tick patterns out of time; margins 2 before, 3 after
		foreach (coinRows[i])
		begin
			{nUp, nDn, nStart, nEnd} = '0;
			stampIn <= {8'hA5, 2'b00, coinRows[i].p};
			fire(coinRows[i].p, CT, 1'b0);
			`CHK(nUp > 0, coinRows[i].t)
			`CHK(nDn, nUp)
			`CHK(nStart > 0 && nEnd > 0, coinRows[i].t)
			if (coinRows[i].t)
			begin
				`CHK(winLast - winFirst, 8'h05)
				apb(1'b0, ets_pkg::OFF_STAMP, 32'h00000000);
				`CHK(rdv, {16'h0000, stampIn})
			end
		end
		// six in-time candidates, factor three
		apb(1'b1, ets_pkg::OFF_PRESCALE, 32'h00000003);
		nUp = 0;
		repeat (6) fire(COIN, 2 * CT, 1'b1);
		`CHK(nUp, 6 / 3)
		// long coincidence loads every plane
		{nUp, clash} = '0;
		fire(COIN, 40 * CT, 1'b0);
		`CHK(nUp >= NP, 1'b1)
		`CHK(clash, 0)
		for (int k = 0; k < NP; k++)
			`CHK(upErr[k] | dnErr[k], 8'h00)
		// three out-of-time rows, two prescaled, forty from the long run
		apb(1'b0, ets_pkg::OFF_TRIGCNT, 32'h00000000);
		`CHK(rdv, 32'(3 + 6 / 3 + 40))
		// second reset restores the factor
		rst <= 1'b1;
		repeat (2) @(posedge core_clk);
		rst <= 1'b0;
		apb(1'b0, ets_pkg::OFF_PRESCALE, 32'h00000000);
		`CHK(rdv, 32'h0000000A)
		apb(1'b0, ets_pkg::OFF_TRIGCNT, 32'h00000000);
		`CHK(rdv, 32'h00000000)
		// status: tick inside one bunch, in-time bit agrees, no pulse
		apb(1'b0, ets_pkg::OFF_STATUS, 32'h00000000);
		`CHK(rdv[8:2] < 7'(ets_pkg::TICK_PER_BUNCH), 1'b1)
		`CHK(rdv[0], rdv[8:2] < 7'(ets_pkg::INTIME_TICKS))
		`CHK(rdv[1], 1'b0)
		results();
	end
endmodule
`default_nettype wire
